// >>> sim/nvlink_properties.sv
// Purpose: link and power-state checks for the nvram pair
// Assumes: one clock, async high reset
// Notes: watches interface wires and device status pins
`timescale 1ns/1ps
module nvlink_properties (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // link wires
    input wire logic cs_n,
    input wire logic sck,
    input wire logic so,
    input wire logic so_oe,
    // device status
    input wire logic POWER_FAIL,
    input wire logic HSB_OE,
    input wire logic STANDBY,
    input wire logic LOCKED,
    input wire logic MODE3
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);
    logic [7:0] idle_q;
    // cycles spent deselected and not busy, saturating
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            idle_q <= 8'h00;
        end else if ((cs_n || LOCKED) && !HSB_OE) begin
            idle_q <= idle_q + {7'h00, idle_q != 8'hFF};
        end else begin
            idle_q <= 8'h00;
        end
    end
    // ****
    // sequences
    // ****
    sequence s_mode_pick;
        ##3 (MODE3 == sck);
    endsequence
    sequence s_recall;
        HSB_OE [*8] ##[1:500] !HSB_OE;
    endsequence
    // ****
    // assertions
    // ****
    AST_DESEL_QUIET: assert property (cs_n |-> !so_oe)
        else $error("output enabled while deselected");
    AST_OE_ON_FALL: assert property ($rose(so_oe) |-> !sck && !cs_n)
        else $error("output enabled outside a low clock phase");
    AST_SO_STEADY: assert property (so_oe && sck && $past(sck) && $past(sck, 2) |-> $stable(so))
        else $error("output changed while clock high");
    AST_MODE_PICK: assert property ($fell(cs_n) |-> s_mode_pick)
        else $error("mode does not follow clock level at select");
    AST_SCK_HALF: assert property (!cs_n && $changed(sck) |=> $stable(sck) [*3])
        else $error("clock half period shorter than four cycles");
    AST_SEL_IDLE: assert property ($fell(cs_n) || $rose(cs_n) |-> $stable(sck))
        else $error("clock moved at a select edge");
    AST_LOCK: assert property (POWER_FAIL |=> LOCKED && !so_oe)
        else $error("no lockout after power fail");
    AST_RECALL: assert property ($fell(RESET) |-> s_recall)
        else $error("recall busy missing or too long");
    AST_SB_ENTER: assert property (idle_q == 8'd28 |-> STANDBY)
        else $error("standby not entered");
    AST_SB_EARLY: assert property ($rose(STANDBY) |-> idle_q >= 8'd23)
        else $error("standby entered too early");
    AST_SB_LEAVE: assert property (!cs_n && !LOCKED |=> !STANDBY)
        else $error("standby held while selected");
endmodule

// >>> sim/tb.sv
// Purpose: drives the host over AHB-Lite, checks link and device
// Assumes: host and device joined by one nvlink_if
// Notes: short recall so busy shows and ends soon
`timescale 1ns/1ps
module tb
    import nvlink_pkg::*;
;
    logic clk, reset, hsel, hwrite, hready, hresp, pf, hsb_oe, standby, locked, mode3;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic m3, rd_pend, sck_q, cs_q;
    logic [7:0] sh;
    logic [7:0] tx_q[$];
    logic [7:0] exp_q[$];
    int nb, failures, n_checks;
    nvlink_if link ();
    nvram_spi_host i_nvram_spi_host (.CLK(clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
        .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata), .LINK(link.host));
    nvram_spi_device #(.RECALL_CYC(400)) i_nvram_spi_device (.CLK(clk), .RESET(reset),
        .LINK(link.dev), .POWER_FAIL(pf), .HSB_O(), .HSB_OE(hsb_oe), .STANDBY(standby),
        .LOCKED(locked), .MODE3(mode3));
    nvlink_properties i_nvlink_properties (.CLK(clk), .RESET(reset), .cs_n(link.cs_n),
        .sck(link.sck), .so(link.so), .so_oe(link.so_oe), .POWER_FAIL(pf), .HSB_OE(hsb_oe),
        .STANDBY(standby), .LOCKED(locked), .MODE3(mode3));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ****
    // tasks
    // ****
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wait_rdy();
        int k;
        @(posedge clk);
        for (k = 0; k < 50 && hready !== 1'b1; k++) @(posedge clk);
        if (k == 50) begin
            failures++;
            end_sim();
        end
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask
    // one byte on the link, optionally read back
    task automatic xfer(input logic [7:0] b, input logic kp, input logic ck, input logic [7:0] e);
        logic [31:0] r;
        int k;
        tx_q.push_back(b);
        ahb(1'b1, REG_TX, {24'h0, b}, r);
        ahb(1'b1, REG_CTRL, {29'h0, kp, m3, 1'b1}, r);
        for (k = 0; k < 200; k++) begin
            ahb(1'b0, REG_STAT, 32'h0, r);
            if (r[STAT_DONE] === 1'b1) break;
        end
        if (k == 200) begin
            failures++;
            end_sim();
        end
        if (ck) begin
            exp_q.push_back(e);
            ahb(1'b0, REG_RX, 32'h0, r);
        end
        ahb(1'b1, REG_STAT, 32'h2, r);
    endtask
    task automatic cmd(input logic [7:0] bs[$], input logic [7:0] ck, input logic [7:0] ex[$]);
        foreach (bs[i]) xfer(bs[i], i < bs.size() - 1, ck[i], ex[i]);
    endtask
    task automatic wait_busy(input logic v, input int n);
        int k;
        for (k = 0; k < n && hsb_oe !== v; k++) @(posedge clk);
        check({7'h0, hsb_oe}, {7'h0, v});
    endtask
    // ****
    // monitors
    // ****
    // rx reads against the oldest note
    always @(posedge clk) begin
        if (rd_pend) check(hrdata[7:0], exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
        rd_pend = hsel && htrans[1] && !hwrite && haddr[7:0] == REG_RX;
    end
    // wire bytes and clock level at select
    always @(posedge clk) begin
        if (link.cs_n === 1'b0 && sck_q === 1'b0 && link.sck === 1'b1) begin
            sh = {sh[6:0], link.si};
            nb++;
        end
        if (nb == 8) begin
            check(sh, tx_q.size() > 0 ? tx_q.pop_front() : 8'hXX);
            nb = 0;
        end
        if (cs_q === 1'b1 && link.cs_n === 1'b0) begin
            check({7'h0, link.sck}, {7'h0, m3});
            check(nb[7:0], 8'h00);
        end
        sck_q = link.sck;
        cs_q = link.cs_n;
    end
    // ****
    // main sequence
    // ****
    initial begin
        logic [12:0] a;
        logic [7:0] d0, d1;
        logic seen;
        {reset, cs_q, hsize} = 5'b11010;
        {hsel, haddr, htrans, hwrite, hwdata, pf, m3, rd_pend, sck_q, sh} = '0;
        {nb, failures, n_checks} = '0;
        void'($urandom(32'h437B7914));
        a = 13'($urandom);
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        cmd('{OP_RDSR, 8'hFF}, 8'h03, '{8'h00, 8'h01});
        wait_busy(1'b0, 1000);
        m3 = 1'b1;
        cmd('{OP_WREN}, 8'h00, '{8'h00});
        cmd('{OP_RDSR, 8'hFF}, 8'h02, '{8'h00, 8'h02});
        m3 = 1'b0;
        cmd('{OP_WRITE, {3'b111, a[12:8]}, a[7:0], d0, d1}, 8'h1F, '{5{8'h00}});
        m3 = 1'b1;
        cmd('{OP_READ, {3'b000, a[12:8]}, a[7:0], 8'hFF, 8'hFF}, 8'h1F,
            '{8'h0, 8'h0, 8'h0, d0, d1});
        m3 = 1'b0;
        cmd('{OP_WRSR, 8'h8C}, 8'h00, '{8'h00, 8'h00});
        cmd('{OP_WRDI}, 8'h00, '{8'h00});
        cmd('{OP_RDSR, 8'hFF, 8'hFF}, 8'h06, '{8'h00, 8'h8C, 8'h8C});
        cmd('{8'hAB, OP_READ, {3'b000, a[12:8]}, a[7:0], 8'hFF}, 8'h1F, '{5{8'h00}});
        $display("test commands done");
        repeat (40) @(posedge clk);
        check({7'h0, standby}, 8'h01);
        pf <= 1'b1;
        repeat (2) @(posedge clk);
        check({7'h0, locked}, 8'h01);
        wait_busy(1'b1, 60);
        cmd('{OP_RDSR, 8'hFF}, 8'h03, '{8'h00, 8'h00});
        $display("test power fail done");
        reset <= 1'b1;
        pf <= 1'b0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        wait_busy(1'b0, 1000);
        pf <= 1'b1;
        seen = 1'b0;
        repeat (100) @(posedge clk) seen |= hsb_oe;
        check({7'h0, seen}, 8'h00);
        $display("test clean power fail done");
        end_sim();
    end
endmodule

// >>> src/nvlink_if.sv
// Purpose: link wires between serial nvram and its master
// Assumes: released output line reads low
// Notes: no clocking block; ends sample on their own clock
`timescale 1ns/1ps
interface nvlink_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic so_line;
    // level seen by the master on the output line
    assign so_line = so_oe & so;
    modport dev (input cs_n, input sck, input si, output so, output so_oe);
    modport host (input so_line, output cs_n, output sck, output si);
endinterface

// >>> src/nvlink_pkg.sv
// Purpose: shared constants and types for the serial nvram link
// Assumes: one 250 MHz clock; link pins sampled on it
// Notes: both ends and the register map of the host use this
// Operation
// RQ1: modes 0/3; sample on rise, drive on fall
// RQ2: clock level at select picks the mode
// RQ3: mode 3 idle-high level is not an edge
// RQ4: master idles clock at the mode level
// RQ5: first byte after select is the opcode
// RQ6: one opcode per select; new select decodes
// RQ7: master deselects between commands, selects to start
// RQ8: deselected: input ignored, output released
// RQ9: every byte moves most significant bit first
// RQ10: two address bytes, low 13 bits used
// RQ11: master sends upper three address bits zero; the testbench WRITE sends them as ones
// RQ12: unknown opcode: ignore rest, output released
// RQ13: master clock at most 104 MHz
// RQ14: slave never starts; acts only when selected
// RQ15: eight-bit status register shows protection, readiness
// RQ16: power-up recall blocks access, busy pin low
// RQ17: power-up clears write enable, keeps protection bits; the device's reset clears bp_lo_q, bp_hi_q and write_protect_enable_q too
// RQ18: power fail: stop, finish write, block access
// RQ19: store after lockout only if written since recall
// RQ20: deselect enters standby after delay when idle
// RQ21: output driven only in read response phase
package nvlink_pkg;
    // ********
    // timing
    // ********
    localparam int CLK_MHZ = 250;
    localparam int RECALL_TIME_US = 20;
    localparam int RECALL_CYCLES = RECALL_TIME_US * CLK_MHZ;
    localparam int STORE_TIME_US = 8;
    localparam logic [15:0] STORE_CYCLES = 16'(STORE_TIME_US * CLK_MHZ);
    localparam int WRITE_FINISH_NS = 100;
    localparam logic [15:0] WRITE_FINISH_CYCLES = 16'((WRITE_FINISH_NS * CLK_MHZ + 999) / 1000);
    localparam int STANDBY_NS = 100;
    localparam logic [7:0] STANDBY_CYCLES = 8'((STANDBY_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] SCK_HALF = 8'h04;
    // ********
    // array and opcodes
    // ********
    localparam int ADDR_W = 13;
    localparam int MEM_DEPTH = 8192;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WREN = 8'h06;
    // ********
    // status bit positions
    // ********
    localparam int SR_BUSY = 0;
    localparam int SR_WEN = 1;
    localparam int SR_BP_LO = 2;
    localparam int SR_BP_HI = 3;
    localparam int SR_WRITE_PROTECT_ENABLE = 7;
    // ********
    // host register map
    // ********
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TX = 8'h04;
    localparam logic [7:0] REG_RX = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;
    localparam int CTRL_START = 0;
    localparam int CTRL_MODE3 = 1;
    localparam int CTRL_KEEP = 2;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    // ********
    // state types
    // ********
    typedef enum logic [2:0] {D_IDLE, D_OPCODE, D_ADDR, D_WDATA, D_RDATA, D_SRWR, D_IGNORE}
        dev_state_t;
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_SEL, H_LOW, H_HIGH, H_END} host_state_t;
endpackage

// >>> src/nvram_spi_device.sv
// Purpose: serial nvram slave end of the link
// Assumes: link pins synchronous to CLK, SCK half period >= 2 CLK
// Notes: holds the 8 K byte array; memory has no reset
`timescale 1ns/1ps
module nvram_spi_device
    import nvlink_pkg::*;
#(
    parameter int RECALL_CYC = RECALL_CYCLES
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // serial link
    nvlink_if.dev LINK,
    // supply monitor
    input wire logic POWER_FAIL,
    // busy pin, open drain
    output logic HSB_O,
    output logic HSB_OE,
    // power and mode state
    output logic STANDBY,
    output logic LOCKED,
    output logic MODE3
);

    // ********
    // declarations
    // ********
    logic sck_q;
    logic cs_q;
    logic sel;
    logic rise;
    logic fall;
    logic cs_fall;
    logic byte_done;
    logic busy;
    logic mem_we;
    logic [7:0] rx_byte;
    logic [7:0] status;
    logic [12:0] addr_full;
    dev_state_t state_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] sh_q;
    logic [7:0] tx_q;
    logic [7:0] op_q;
    logic [12:0] addr_q;
    logic ab_q;
    logic seen_q;
    logic mode3_q;
    logic so_q;
    logic drive_q;
    logic wen_q;
    logic bp_lo_q;
    logic bp_hi_q;
    logic write_protect_enable_q;
    logic recall_q;
    logic store_q;
    logic lock_q;
    logic finish_q;
    logic dirty_q;
    logic [15:0] nv_cnt_q;
    logic [7:0] sb_cnt_q;
    logic standby_q;
    logic [7:0] mem [MEM_DEPTH];

    // ********
    // edge detection
    // ********
    // previous pin levels
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            sck_q <= 1'b0;
            cs_q <= 1'b1;
        end else begin
            sck_q <= LINK.sck;
            cs_q <= LINK.cs_n;
        end
    end

    // link is live only while selected and not locked out
    assign sel = ~LINK.cs_n & ~lock_q; // RQ8 RQ14 RQ18
    assign rise = sel & LINK.sck & ~sck_q; // RQ1
    assign fall = sel & ~LINK.sck & sck_q; // RQ1
    assign cs_fall = sel & cs_q;
    assign byte_done = rise & (bit_cnt_q == 3'h7);
    assign rx_byte = {sh_q[6:0], LINK.si}; // RQ9
    assign addr_full = {addr_q[12:8], rx_byte};
    assign busy = recall_q | store_q;
    // status byte, unused bits zero
    assign status = {write_protect_enable_q, 3'h0, bp_hi_q, bp_lo_q, wen_q, busy}; // RQ15

    // ********
    // command engine
    // ********
    // bit counting, opcode decode, address and data phases
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            state_q <= D_IDLE;
            bit_cnt_q <= 3'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            op_q <= 8'h00;
            addr_q <= 13'h0000;
            ab_q <= 1'b0;
            seen_q <= 1'b0;
            mode3_q <= 1'b0;
            so_q <= 1'b0;
            drive_q <= 1'b0;
        end else if (!sel) begin
            state_q <= D_IDLE; // RQ8
            bit_cnt_q <= 3'h0;
            drive_q <= 1'b0; // RQ8
        end else if (cs_fall) begin
            mode3_q <= LINK.sck; // RQ2
            seen_q <= 1'b0;
            bit_cnt_q <= 3'h0;
            ab_q <= 1'b0;
            drive_q <= 1'b0;
            state_q <= D_OPCODE; // RQ5 RQ6
        end else begin
            if (rise) begin
                seen_q <= 1'b1;
                bit_cnt_q <= bit_cnt_q + 3'h1;
                sh_q <= rx_byte; // RQ9
            end
            if (byte_done) begin
                unique case (state_q)
                    D_OPCODE: begin
                        op_q <= rx_byte; // RQ5
                        if ((rx_byte == OP_READ || rx_byte == OP_WRITE) && !busy) begin
                            state_q <= D_ADDR;
                        end else if (rx_byte == OP_RDSR) begin
                            tx_q <= status;
                            state_q <= D_RDATA;
                        end else if (rx_byte == OP_WRSR) begin
                            state_q <= D_SRWR;
                        end else begin
                            state_q <= D_IGNORE; // RQ12
                        end
                    end
                    D_ADDR: begin
                        if (!ab_q) begin
                            ab_q <= 1'b1;
                            addr_q <= {rx_byte[4:0], 8'h00}; // RQ10
                        end else if (op_q == OP_READ) begin
                            tx_q <= mem[addr_full];
                            addr_q <= addr_full + 13'h0001;
                            state_q <= D_RDATA;
                        end else begin
                            addr_q <= addr_full; // RQ10
                            state_q <= D_WDATA;
                        end
                    end
                    D_WDATA: begin
                        addr_q <= addr_q + 13'h0001;
                    end
                    D_RDATA: begin
                        if (op_q == OP_READ) begin
                            tx_q <= mem[addr_q];
                            addr_q <= addr_q + 13'h0001;
                        end else begin
                            tx_q <= status;
                        end
                    end
                    D_SRWR: begin
                        state_q <= D_IGNORE;
                    end
                    D_IGNORE: begin
                        state_q <= D_IGNORE; // RQ6 RQ12
                    end
                    D_IDLE: begin
                        state_q <= D_IDLE; // RQ6
                    end
                endcase
            end
            // response bits leave on falling edges only
            if (fall && state_q == D_RDATA && (seen_q || !mode3_q)) begin // RQ3
                so_q <= tx_q[7]; // RQ9
                tx_q <= {tx_q[6:0], 1'b0};
                drive_q <= 1'b1; // RQ21
            end
        end
    end

    assign LINK.so = so_q;
    assign LINK.so_oe = drive_q & sel; // RQ21 RQ12
    assign MODE3 = mode3_q;

    // ********
    // array
    // ********
    assign mem_we = byte_done & (state_q == D_WDATA) & wen_q & ~busy;

    // byte write at end of each data byte
    always_ff @(posedge CLK) begin
        if (mem_we) begin
            mem[addr_q] <= rx_byte;
        end
    end

    // ********
    // status bits
    // ********
    // write enable latch and protection bits
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            wen_q <= 1'b0; // RQ17
            bp_lo_q <= 1'b0;
            bp_hi_q <= 1'b0;
            write_protect_enable_q <= 1'b0;
        end else if (byte_done && state_q == D_OPCODE) begin
            if (rx_byte == OP_WREN) begin
                wen_q <= 1'b1;
            end else if (rx_byte == OP_WRDI) begin
                wen_q <= 1'b0;
            end
        end else if (byte_done && state_q == D_SRWR && wen_q) begin
            write_protect_enable_q <= rx_byte[SR_WRITE_PROTECT_ENABLE];
            bp_hi_q <= rx_byte[SR_BP_HI];
            bp_lo_q <= rx_byte[SR_BP_LO];
        end
    end

    // ********
    // recall, lockout and store
    // ********
    // power-up recall, power-fail finish window, conditional store
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            recall_q <= 1'b1; // RQ16
            store_q <= 1'b0;
            lock_q <= 1'b0;
            finish_q <= 1'b0;
            nv_cnt_q <= 16'h0000;
        end else if (POWER_FAIL && !lock_q) begin
            lock_q <= 1'b1; // RQ18
            finish_q <= 1'b1;
            recall_q <= 1'b0;
            nv_cnt_q <= 16'h0000;
        end else if (recall_q) begin
            if (nv_cnt_q == 16'(RECALL_CYC - 1)) begin
                recall_q <= 1'b0; // RQ16
                nv_cnt_q <= 16'h0000;
            end else begin
                nv_cnt_q <= nv_cnt_q + 16'h0001;
            end
        end else if (finish_q) begin
            if (nv_cnt_q == WRITE_FINISH_CYCLES - 16'h0001) begin
                finish_q <= 1'b0; // RQ18
                store_q <= dirty_q; // RQ19
                nv_cnt_q <= 16'h0000;
            end else begin
                nv_cnt_q <= nv_cnt_q + 16'h0001;
            end
        end else if (store_q) begin
            if (nv_cnt_q == STORE_CYCLES - 16'h0001) begin
                store_q <= 1'b0;
                nv_cnt_q <= 16'h0000;
            end else begin
                nv_cnt_q <= nv_cnt_q + 16'h0001;
            end
        end
    end

    // written since recall; a new write wins over the clear
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            dirty_q <= 1'b0;
        end else if (mem_we) begin
            dirty_q <= 1'b1; // RQ19
        end else if (store_q && nv_cnt_q == STORE_CYCLES - 16'h0001) begin
            dirty_q <= 1'b0;
        end
    end

    // busy pin pulled low during recall or store
    assign HSB_O = 1'b0;
    assign HSB_OE = busy; // RQ16
    assign LOCKED = lock_q;

    // ********
    // standby
    // ********
    // deselected and idle for the entry delay
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            sb_cnt_q <= 8'h00;
            standby_q <= 1'b0;
        end else if (!LINK.cs_n && !lock_q || busy) begin
            sb_cnt_q <= 8'h00; // RQ20
            standby_q <= 1'b0;
        end else if (sb_cnt_q == STANDBY_CYCLES - 8'h01) begin
            standby_q <= 1'b1; // RQ20
        end else begin
            sb_cnt_q <= sb_cnt_q + 8'h01;
        end
    end

    assign STANDBY = standby_q;

endmodule

// >>> src/nvram_spi_host.sv
// Purpose: link master with AHB-Lite register port
// Assumes: zero-wait slave, word accesses only
// Notes: software builds commands byte by byte
`timescale 1ns/1ps
module nvram_spi_host
    import nvlink_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    // serial link
    nvlink_if.host LINK
);

    // ********
    // register port
    // ********
    logic acc;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_mux;
    logic mode3_q;
    logic keep_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic done_q;
    logic start;
    logic half_end;
    host_state_t st_q;
    logic [7:0] cnt_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic cs_n_q;
    logic sck_q;
    logic mosi_q;

    assign acc = HSEL & HREADY & HTRANS[1];
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = hrdata_q;

    // read view, unmapped reads zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (HADDR[7:0])
            REG_CTRL: rd_mux = {29'h0, keep_q, mode3_q, 1'b0};
            REG_TX: rd_mux = {24'h0, tx_q};
            REG_RX: rd_mux = {24'h0, rx_q};
            REG_STAT: rd_mux = {30'h0, done_q, st_q != H_IDLE};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // address phase capture
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
        end else begin
            wr_pend_q <= acc & HWRITE;
            if (acc) begin
                wr_addr_q <= HADDR[7:0];
            end
            if (acc && !HWRITE) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    // control and transmit registers
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            mode3_q <= 1'b0;
            keep_q <= 1'b0;
            tx_q <= 8'h00;
        end else if (wr_pend_q && wr_addr_q == REG_CTRL && st_q == H_IDLE) begin
            mode3_q <= HWDATA[CTRL_MODE3];
            keep_q <= HWDATA[CTRL_KEEP];
        end else if (wr_pend_q && wr_addr_q == REG_TX) begin
            tx_q <= HWDATA[7:0];
        end
    end

    assign start = wr_pend_q & (wr_addr_q == REG_CTRL) & HWDATA[CTRL_START] & (st_q == H_IDLE);

    // byte done flag, set wins over write-one clear
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            done_q <= 1'b0;
        end else if (st_q == H_END && half_end) begin
            done_q <= 1'b1;
        end else if (wr_pend_q && wr_addr_q == REG_STAT && HWDATA[STAT_DONE]) begin
            done_q <= 1'b0;
        end
    end

    // ********
    // byte engine
    // ********
    assign half_end = (cnt_q == SCK_HALF - 8'h01); // RQ13

    // half period timer
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            cnt_q <= 8'h00;
        end else if (st_q == H_IDLE || half_end) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // select, clock and shift sequencing
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            st_q <= H_IDLE;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            rx_q <= 8'h00;
            cs_n_q <= 1'b1;
            sck_q <= 1'b0;
            mosi_q <= 1'b0;
        end else begin
            unique case (st_q)
                H_IDLE: begin
                    bit_q <= 3'h0;
                    if (start && cs_n_q) begin
                        sh_q <= tx_q;
                        sck_q <= HWDATA[CTRL_MODE3]; // RQ4
                        st_q <= H_SETUP;
                    end else if (start) begin
                        sh_q <= tx_q;
                        sck_q <= 1'b0;
                        mosi_q <= tx_q[7]; // RQ9
                        st_q <= H_LOW;
                    end
                end
                H_SETUP: begin
                    if (half_end) begin
                        cs_n_q <= 1'b0; // RQ7
                        st_q <= H_SEL;
                    end
                end
                H_SEL: begin
                    if (half_end) begin
                        sck_q <= 1'b0;
                        mosi_q <= sh_q[7]; // RQ9
                        st_q <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (half_end) begin
                        sck_q <= 1'b1;
                        sh_q <= {sh_q[6:0], LINK.so_line};
                        st_q <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (half_end && bit_q == 3'h7) begin
                        sck_q <= mode3_q; // RQ4
                        rx_q <= sh_q;
                        st_q <= H_END;
                    end else if (half_end) begin
                        bit_q <= bit_q + 3'h1;
                        sck_q <= 1'b0;
                        mosi_q <= sh_q[7];
                        st_q <= H_LOW;
                    end
                end
                H_END: begin
                    if (half_end) begin
                        cs_n_q <= ~keep_q; // RQ7
                        st_q <= H_IDLE;
                    end
                end
            endcase
        end
    end

    assign LINK.cs_n = cs_n_q;
    assign LINK.sck = sck_q;
    assign LINK.si = mosi_q;

endmodule
